// *** logic/irq_unit.sv ***
// vectored priority interrupt unit top
`timescale 1ns/10ps
module irq_unit (
	// clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic clk_en,
	// request sources
	input wire logic [3:0] port_irq_lines,
	input wire logic serial_rx_event,
	input wire logic serial_tx_event,
	input wire logic counter_timer_zero,
	input wire logic counter_timer_one,
	// software control
	input wire logic global_en_wr,
	input wire logic global_en_val,
	input wire logic mask_wr,
	input wire logic [5:0] mask_val,
	input wire logic prio_wr,
	input wire logic [2:0] prio_val,
	input wire logic [5:0] req_clear,
	input wire logic serial_sel_tx,
	// core sequencer
	input wire logic core_ready,
	input wire logic [7:0] vector_byte,
	input wire logic reti,
	// outputs
	output logic [5:0] req_pending,
	output logic [5:0] mask_out,
	output logic global_en_out,
	output irq_unit_pkg::core_req_t core_req
);
	typedef struct packed {
		logic [1:0] rst_sync;
		irq_unit_pkg::edge_state_t edg;
		logic [5:0] req;
		logic [5:0] mask;
		logic gen;
		logic [2:0] prio;
		irq_unit_pkg::cyc_state_t st;
		logic [2:0] gid;
		logic [7:0] vec_hi;
		irq_unit_pkg::core_req_t cr;
	} state_t;

	state_t s_r, s_nxt;
	logic rst_n;
	logic [5:0] raw, rise, eligible;
	logic found;
	logic [2:0] winner;
	logic [15:0] vaddr;
	logic grant_now;
	logic [5:0] req_upd;
	state_t s_init;

	// ----------------------------------------
	// reset release
	// ----------------------------------------
	assign rst_n = s_r.rst_sync[1];

	// held state while the internal reset is low
	always_comb begin
		s_init = '0;
		s_init.rst_sync = {s_r.rst_sync[0], 1'b1};
		s_init.req = irq_unit_pkg::REQ_RST;
		s_init.mask = irq_unit_pkg::MASK_RST;
		s_init.gen = irq_unit_pkg::GLOBAL_RST;
		s_init.st = irq_unit_pkg::ST_IDLE;
	end

	// ----------------------------------------
	// source gathering
	// ----------------------------------------
	always_comb begin
		raw[3:0] = port_irq_lines;
		raw[irq_unit_pkg::REQ_TIMER0] = counter_timer_zero;
		raw[irq_unit_pkg::REQ_TIMER1] = counter_timer_one;
	end

	// ----------------------------------------
	// edge detection
	// ----------------------------------------
	// serial events share a line with port line d
	always_comb begin
		rise = s_r.edg.sync2 & ~s_r.edg.prev;
		rise[3] = rise[3] |
			(serial_sel_tx ? serial_tx_event : serial_rx_event);
		eligible = s_r.req & s_r.mask & {6{s_r.gen}};
	end

	// ----------------------------------------
	// priority selection
	// ----------------------------------------
	prio_select u_prio (
		.eligible(eligible),
		.prio_sel(s_r.prio),
		.found(found),
		.winner(winner)
	);

	// ----------------------------------------
	// grant decision
	// ----------------------------------------
	// no grant while a cycle runs or waits for its return
	assign grant_now = found && !s_r.cr.in_cycle &&
		(s_r.st == irq_unit_pkg::ST_IDLE);

	// ----------------------------------------
	// pending flags, one per request
	// ----------------------------------------
	for (genvar g = 0; g < irq_unit_pkg::NUM_REQ; g++) begin : g_req
		logic taken;
		assign taken = grant_now && (winner == 3'(g));
		// a new event wins over a clear or a grant
		assign req_upd[g] = rise[g] |
			(s_r.req[g] & ~req_clear[g] & ~taken);
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		s_nxt = s_r;
		vaddr = irq_unit_pkg::VEC_BASE +
			16'(s_r.gid) * irq_unit_pkg::VEC_STRIDE;
		s_nxt.rst_sync = {s_r.rst_sync[0], 1'b1};
		s_nxt.edg.sync1 = raw;
		s_nxt.edg.sync2 = s_r.edg.sync1;
		s_nxt.edg.prev = s_r.edg.sync2;
		if (mask_wr)
			s_nxt.mask = mask_val;
		if (prio_wr)
			s_nxt.prio = prio_val;
		if (global_en_wr)
			s_nxt.gen = global_en_val;
		s_nxt.req = req_upd;
		s_nxt.cr.save_valid = 1'b0;
		s_nxt.cr.fetch_valid = 1'b0;
		s_nxt.cr.branch_valid = 1'b0;
		unique case (s_r.st)
			irq_unit_pkg::ST_IDLE: begin
				if (grant_now) begin
					s_nxt.gid = winner;
					s_nxt.cr.in_cycle = 1'b1;
					s_nxt.cr.grant_id = winner;
					s_nxt.st = irq_unit_pkg::ST_SAVE_PC_LO;
				end else if (reti) begin
					s_nxt.cr.in_cycle = 1'b0;
				end
			end
			irq_unit_pkg::ST_SAVE_PC_LO: begin
				s_nxt.cr.save_valid = 1'b1;
				s_nxt.cr.save_sel = 2'h0;
				if (core_ready && s_r.cr.save_valid) begin
					s_nxt.cr.save_valid = 1'b0;
					s_nxt.st = irq_unit_pkg::ST_SAVE_PC_HI;
				end
			end
			irq_unit_pkg::ST_SAVE_PC_HI: begin
				s_nxt.cr.save_valid = 1'b1;
				s_nxt.cr.save_sel = 2'h1;
				if (core_ready && s_r.cr.save_valid) begin
					s_nxt.cr.save_valid = 1'b0;
					s_nxt.st = irq_unit_pkg::ST_SAVE_FLAGS;
				end
			end
			irq_unit_pkg::ST_SAVE_FLAGS: begin
				s_nxt.cr.save_valid = 1'b1;
				s_nxt.cr.save_sel = 2'h2;
				if (core_ready && s_r.cr.save_valid) begin
					s_nxt.cr.save_valid = 1'b0;
					s_nxt.st = irq_unit_pkg::ST_FETCH_HI;
				end
			end
			irq_unit_pkg::ST_FETCH_HI: begin
				s_nxt.cr.fetch_valid = 1'b1;
				s_nxt.cr.fetch_addr = vaddr;
				if (core_ready && s_r.cr.fetch_valid) begin
					s_nxt.vec_hi = vector_byte;
					s_nxt.st = irq_unit_pkg::ST_FETCH_LO;
					s_nxt.cr.fetch_valid = 1'b0;
				end
			end
			irq_unit_pkg::ST_FETCH_LO: begin
				s_nxt.cr.fetch_valid = 1'b1;
				s_nxt.cr.fetch_addr = vaddr + 16'h0001;
				if (core_ready && s_r.cr.fetch_valid) begin
					s_nxt.cr.branch_addr = {s_r.vec_hi, vector_byte};
					s_nxt.cr.fetch_valid = 1'b0;
					s_nxt.st = irq_unit_pkg::ST_BRANCH;
				end
			end
			irq_unit_pkg::ST_BRANCH: begin
				s_nxt.cr.branch_valid = 1'b1;
				s_nxt.st = irq_unit_pkg::ST_IDLE;
			end
			default: s_nxt.st = irq_unit_pkg::ST_IDLE;
		endcase
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_r <= '0;
		end else if (!rst_n) begin
			s_r <= s_init;
		end else if (clk_en) begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	always_comb begin
		req_pending = s_r.req;
		mask_out = s_r.mask;
		global_en_out = s_r.gen;
		core_req = s_r.cr;
	end
endmodule : irq_unit

// *** common/irq_unit_pkg.sv ***
// constants and carrier types of the vectored priority interrupt unit
// Behaviour
// - six requests gathered from eight sources
// - global and per-request enables mask requests
// - programmable priority encoder picks among pending
// - grant starts interrupt cycle, disables further interrupts
// - cycle saves pc and flags, then vectors
// - address from vector byte and next byte
// - each request owns a distinct vector location
// - request flags visible even when masked
// - lowest twelve bytes hold six vectors
// - timer ends of count raise requests four, five
// - four port lines raise requests zero to three
package irq_unit_pkg;
	localparam int NUM_REQ = 6;
	localparam int PRIO_W = 3;
	localparam logic [15:0] VEC_BASE = 16'h0000;
	localparam logic [15:0] VEC_STRIDE = 16'h0002;
	localparam logic [NUM_REQ-1:0] REQ_RST = 6'h00;
	localparam logic [NUM_REQ-1:0] MASK_RST = 6'h00;
	localparam logic GLOBAL_RST = 1'h0;
	localparam int REQ_TIMER0 = 4;
	localparam int REQ_TIMER1 = 5;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_SAVE_PC_LO = 3'h1,
		ST_SAVE_PC_HI = 3'h2,
		ST_SAVE_FLAGS = 3'h3,
		ST_FETCH_HI = 3'h4,
		ST_FETCH_LO = 3'h5,
		ST_BRANCH = 3'h6
	} cyc_state_t;

	// request into the core sequencer, with save and fetch strobes
	typedef struct packed {
		logic in_cycle;
		logic save_valid;
		logic [1:0] save_sel;
		logic fetch_valid;
		logic [15:0] fetch_addr;
		logic branch_valid;
		logic [15:0] branch_addr;
		logic [2:0] grant_id;
	} core_req_t;

	typedef struct packed {
		logic [5:0] sync1;
		logic [5:0] sync2;
		logic [5:0] prev;
	} edge_state_t;
endpackage : irq_unit_pkg

// *** logic/prio_select.sv ***
// programmable priority selection among enabled pending requests
`timescale 1ns/10ps
module prio_select (
	// inputs
	input wire logic [5:0] eligible,
	input wire logic [2:0] prio_sel,
	// result
	output logic found,
	output logic [2:0] winner
);
	logic [2:0] order [0:5];
	// the setting rotates which request ranks first
	always_comb begin
		found = 1'b0;
		winner = 3'h0;
		for (int i = 0; i < 6; i++) begin
			order[i] = 3'((int'(prio_sel) % 6 + i) % 6);
		end
		for (int i = 5; i >= 0; i--) begin
			if (eligible[order[i]]) begin
				found = 1'b1;
				winner = order[i];
			end
		end
	end
endmodule : prio_select

// *** dv/core_model.sv ***
// core sequencer and vector table stand-in
`timescale 1ns/10ps
module core_model (
	// stall control
	input wire logic stall,
	// interrupt unit side
	input irq_unit_pkg::core_req_t core_req,
	output logic core_ready,
	output logic [7:0] vector_byte
);
	logic [7:0] b;
	assign core_ready = ~stall;
	assign b = core_req.fetch_addr[7:0] ^ 8'hC3;
	assign vector_byte = core_req.fetch_valid ? b : ~b;
endmodule : core_model

// *** dv/irq_unit_asserts.sv ***
// port assertions for the interrupt unit
`timescale 1ns/10ps
module irq_unit_asserts (
	input wire logic core_clk, arst_n, reti, core_ready, global_en_out,
	input wire logic [5:0] req_pending, req_clear,
	input irq_unit_pkg::core_req_t core_req
);
	logic ic, sv, fv, bv;
	assign ic = core_req.in_cycle;
	assign sv = core_req.save_valid;
	assign fv = core_req.fetch_valid;
	assign bv = core_req.branch_valid;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	sequence s_grant; $rose(ic); endsequence
	sequence s_lo; sv && core_req.save_sel == 2'h0 && core_ready; endsequence
	sequence s_hi; sv && core_req.save_sel == 2'h1 && core_ready; endsequence
	sequence s_flags;
		sv && core_req.save_sel == 2'h2 && core_ready;
	endsequence
	sequence s_fetch_hi;
		fv && !core_req.fetch_addr[0] && core_ready;
	endsequence
	a_cycle_holds:
	assert property (ic && !reti |=> ic) else $error("cycle dropped");
	a_save_first:
	assert property (s_grant |-> ##[0:1] sv) else $error("no save");
	a_save_order:
	assert property (s_lo |-> ##[1:2] sv && core_req.save_sel == 2'h1)
		else $error("bad save order");
	a_save_flags:
	assert property (s_hi |-> ##[1:2] sv && core_req.save_sel == 2'h2)
		else $error("no flags save");
	a_fetch_first:
	assert property (s_flags |-> ##[1:2] fv && !core_req.fetch_addr[0])
		else $error("no vector fetch");
	a_fetch_second:
	assert property (s_fetch_hi |-> ##[1:2] fv && core_req.fetch_addr[0])
		else $error("no second byte");
	a_vector_slot:
	assert property (fv |->
		core_req.fetch_addr[15:1] == {12'h000, core_req.grant_id})
		else $error("bad vector slot");
	a_branch_pulse:
	assert property (bv |=> !bv) else $error("long branch");
	a_branch_after:
	assert property (bv |-> ic && $past(fv, 2)) else $error("branch no fetch");
	a_global_off:
	assert property (!global_en_out && !ic |=> !ic) else $error("grant off");
	a_grant_clears:
	assert property (s_grant |-> !req_pending[core_req.grant_id])
		else $error("not cleared");
	a_pend_kept:
	assert property (|($past(req_pending) & ~req_pending & ~$past(req_clear))
		|-> $rose(ic)) else $error("pending lost");
endmodule : irq_unit_asserts

// *** dv/vectored_priority_interrupt_unit_tb.sv ***
// self-checking bench for the interrupt unit
`timescale 1ns/10ps
`define CHK(n,e,s) begin samples_checked++; if ((s) !== (e)) begin \
n_mismatch++; $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
bind irq_unit irq_unit_asserts chk (.*);
module vectored_priority_interrupt_unit_tb;
	logic core_clk = 0, arst_n = 0, clk_en = 1, stall = 0, reti = 0, br;
	logic global_en_wr = 0, global_en_val = 0, mask_wr = 0, prio_wr = 0;
	logic serial_rx_event = 0, serial_tx_event = 0, serial_sel_tx = 0;
	logic counter_timer_zero = 0, counter_timer_one = 0, core_ready;
	logic [3:0] port_irq_lines = 0;
	logic [5:0] mask_val = 0, req_clear = 0, p, req_pending, mask_out;
	logic [2:0] prio_val = 0, w;
	logic [7:0] vector_byte;
	logic [15:0] exp_vec;
	logic global_en_out;
	irq_unit_pkg::core_req_t core_req;
	int seed = 522, sd2 = 522, n_mismatch = 0, samples_checked = 0;
	int cyc = 0, i, t;
	irq_unit DUT (.*);
	core_model PM (.*);
	initial forever #20 core_clk = ~core_clk;
	always @(negedge core_clk) stall <= 1'($random(sd2));
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			stop_test();
		end
	end
	function automatic logic [2:0] win(logic [5:0] e, logic [2:0] r);
		win = 3'h0;
		for (int k = 5; k >= 0; k--) begin
			if (e[(r % 6 + k) % 6])
				win = 3'((r % 6 + k) % 6);
		end
	endfunction : win
	function automatic logic [7:0] vb(logic [3:0] a);
		return {4'h0, a} ^ 8'hC3;
	endfunction : vb
	task wr(logic g);
		@(negedge core_clk);
		{global_en_wr, mask_wr, prio_wr} = 3'h7;
		global_en_val = g;
		@(negedge core_clk);
		{global_en_wr, mask_wr, prio_wr} = 3'h0;
	endtask : wr
	task stop_test;
		if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : stop_test
	initial begin
		repeat (12) @(negedge core_clk);
		arst_n = 1;
		repeat (2) @(negedge core_clk);
		for (i = 0; i < 12; i++) begin
			p = 6'($random(seed));
			mask_val = (i == 0) ? 6'h00 : 6'($random(seed));
			prio_val = 3'($random(seed));
			serial_sel_tx = i[1];
			wr(0);
			port_irq_lines = {p[3] & ~i[0], p[2:0]};
			{counter_timer_one, counter_timer_zero} = p[5:4];
			serial_rx_event = i[0] & (p[3] | serial_sel_tx);
			serial_tx_event = i[0] & (p[3] | ~serial_sel_tx);
			@(negedge core_clk);
			{serial_rx_event, serial_tx_event} = 2'h0;
			repeat (5) @(negedge core_clk);
			`CHK("pending", p, req_pending)
			`CHK("mask", mask_val, mask_out)
			`CHK("global", 1'b0, global_en_out)
			wr(1);
			br = 0;
			for (t = 0; t < 40 && !br; t++) begin
				@(posedge core_clk) #1 br = core_req.branch_valid;
			end
			w = win(p & mask_val, prio_val);
			if (|(p & mask_val)) begin
				`CHK("branch", 1'b1, br)
				`CHK("grant", w, core_req.grant_id)
				exp_vec = {vb({w, 1'b0}), vb({w, 1'b1})};
				`CHK("vector", exp_vec, core_req.branch_addr)
				`CHK("left", p & ~(6'h01 << w), req_pending)
				`CHK("in cycle", 1'b1, core_req.in_cycle)
			end else `CHK("idle", 1'b0, br)
			wr(0);
			reti = 1;
			req_clear = 6'h3F;
			{port_irq_lines, counter_timer_zero, counter_timer_one} = 6'h00;
			@(negedge core_clk);
			reti = 0;
			req_clear = 6'h00;
			repeat (5) @(negedge core_clk);
			`CHK("cleared", 6'h00, req_pending)
			`CHK("released", 1'b0, core_req.in_cycle)
		end
		stop_test();
	end
endmodule : vectored_priority_interrupt_unit_tb
